// ---- atx_pkg.sv ----
package atx_pkg;
   // instruction codes
   localparam logic [7:0] OP_ACCU_TO_COORD = 8'h27;
   localparam logic [7:0] OP_WITH_IMMEDIATE_A_X = 8'h21;
   localparam logic [7:0] OP_ACCU_TO_AXIS = 8'h22;
   localparam logic [7:0] OP_ACCU_TO_GLOBAL = 8'h23;
   // operation types of the x-register calculation
   localparam logic [7:0] TY_ADD = 8'h00;
   localparam logic [7:0] TY_SUB = 8'h01;
   localparam logic [7:0] TY_MUL = 8'h02;
   localparam logic [7:0] TY_DIV = 8'h03;
   localparam logic [7:0] TY_MOD = 8'h04;
   localparam logic [7:0] TY_AND = 8'h05;
   localparam logic [7:0] TY_OR = 8'h06;
   localparam logic [7:0] TY_XOR = 8'h07;
   localparam logic [7:0] TY_NOT = 8'h08;
   localparam logic [7:0] TY_LOAD = 8'h09;
   localparam logic [7:0] TY_SWAP = 8'h0a;
   // reply status codes
   localparam logic [7:0] ST_OK = 8'h64;
   localparam logic [7:0] ST_BAD_CHK = 8'h01;
   localparam logic [7:0] ST_BAD_CMD = 8'h02;
   localparam logic [7:0] ST_BAD_TYPE = 8'h03;
   // coordinate persistence switch
   localparam logic [7:0] GP_COORD_PERSIST = 8'h54;
   localparam logic [7:0] GP_PERSIST_BANK = 8'h00;
   localparam logic PERSIST_RST = 1'b0;
   localparam logic [7:0] COORD_RAM_ONLY = 8'h00;
   // frame byte positions
   localparam logic [3:0] FB_ADDR = 4'h0;
   localparam logic [3:0] FB_OP = 4'h1;
   localparam logic [3:0] FB_TYPE = 4'h2;
   localparam logic [3:0] FB_BANK = 4'h3;
   localparam logic [3:0] FB_VAL_LSB = 4'h7;
   localparam logic [3:0] FB_CHK = 4'h8;
   // divider
   localparam logic [5:0] DIV_LAST = 6'h1f;
   localparam logic [31:0] ACCU_RST = 32'h0000_0000;

   typedef enum logic [1:0] {ATX_IDLE, ATX_EXEC, ATX_DIV} atx_state_t;
endpackage : atx_pkg

// ---- atx_div.sv ----
`timescale 1ns/100ps
module atx_div (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // request
   input wire logic start,
   input wire logic [31:0] dividend,
   input wire logic [31:0] divisor,
   // result
   output logic done,
   output logic [31:0] quotient,
   output logic [31:0] remainder
);
   typedef struct packed {
      logic busy;
      logic done;
      logic [5:0] cnt;
      logic [31:0] rem;
      logic [31:0] quo;
      logic [31:0] dvs;
      logic negq;
      logic negr;
   } atx_div_t;

   atx_div_t st;
   atx_div_t next_st;
   logic [32:0] sh;
   logic [33:0] trial;

   // one bit per cycle on magnitudes; signs restored on the last step
   always_comb begin
      next_st = st;
      next_st.done = 1'b0;
      sh = {st.rem, st.quo[31]};
      trial = {1'b0, sh} - {2'b00, st.dvs};
      if (start) begin
         next_st.busy = 1'b1;
         next_st.cnt = 6'h00;
         next_st.rem = 32'h0000_0000;
         next_st.quo = dividend[31] ? -dividend : dividend;
         next_st.dvs = divisor[31] ? -divisor : divisor;
         next_st.negq = dividend[31] ^ divisor[31];
         next_st.negr = dividend[31];
      end else if (st.busy) begin
         if (!trial[33]) begin
            next_st.rem = trial[31:0];
            next_st.quo = {st.quo[30:0], 1'b1};
         end else begin
            next_st.rem = sh[31:0];
            next_st.quo = {st.quo[30:0], 1'b0};
         end
         next_st.cnt = st.cnt + 6'h01;
         if (st.cnt == atx_pkg::DIV_LAST) begin
            next_st.busy = 1'b0;
            next_st.done = 1'b1;
            if (st.negq) begin
               next_st.quo = -next_st.quo;
            end
            if (st.negr) begin
               next_st.rem = -next_st.rem;
            end
         end
      end
   end

   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign done = st.done;
   assign quotient = st.quo;
   assign remainder = st.rem;

   property p_div_latency;
      @(posedge core_clk) disable iff (!arst_n)
      (start && !st.busy) |-> ##33 done;
   endproperty
   a_div_latency: assert property (p_div_latency) // [RULE_06]
      else $error("divider result not ready after 33 cycles");
endmodule : atx_div

// ---- atx_accu_alu.sv ----
// How it works
// (RULE_01) instruction 39 writes the accumulator to the coordinate chosen by type for the motor in bank; value ignored.
// (RULE_02) coordinate zero is never sent to nonvolatile storage.
// (RULE_03) global parameter 84 selects volatile-only or also nonvolatile coordinates, volatile-only after reset.
// (RULE_04) every accepted direct-mode accumulator instruction replies with status 100 and a meaningless value.
// (RULE_05) instruction 33 combines accumulator and X by the type's operation, result into the accumulator.
// (RULE_06) types 0 to 4 are add, subtract, multiply, divide and modulo of accumulator by X.
// (RULE_07) types 5 to 7 are and, or, xor with X, and type 8 inverts X.
// (RULE_08) type 9 copies the accumulator into X and type 10 swaps them.
// (RULE_09) instruction 34 writes the accumulator to the axis parameter chosen by type for the motor in bank.
// (RULE_10) instruction 35 writes the accumulator to the global parameter chosen by type in the bank.
// (RULE_11) the host sends address, instruction, type, bank, four value bytes msb first, then checksum.
// (RULE_12) a read in direct mode answers in the reply only, while standalone loads the accumulator.
// (RULE_13) the checksum is the byte sum of the first eight bytes and is checked before execution.
// (RULE_14) accumulator and X are 32-bit two's complement and arithmetic wraps.
`timescale 1ns/100ps
module atx_accu_alu #(
   parameter logic [7:0] MODULE_ADDR = 8'h01,
   parameter logic [7:0] READ_AXIS_CODE = 8'h06
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic arst_n,
   // direct-mode frame bytes
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   // standalone instruction
   input wire logic sa_valid,
   input wire logic [7:0] sa_op,
   input wire logic [7:0] sa_type,
   input wire logic [7:0] sa_bank,
   input wire logic [31:0] sa_value,
   output logic sa_ready,
   // reply
   output logic reply_valid,
   output logic [7:0] reply_status,
   output logic [31:0] reply_value,
   // parameter and coordinate stores
   output logic [7:0] sel_type,
   output logic [7:0] sel_bank,
   output logic [31:0] wr_data,
   output logic coord_we,
   output logic coord_nv_we,
   output logic coord_persist,
   output logic ap_we,
   output logic gp_we,
   input wire logic [31:0] ap_rd_data,
   // register view
   output logic [31:0] accu,
   output logic [31:0] x_reg
);
   typedef struct packed {
      atx_pkg::atx_state_t state;
      logic [3:0] cnt;
      logic [7:0] sum;
      logic chk_ok;
      logic adr_ok;
      logic direct;
      logic [7:0] op;
      logic [7:0] typ;
      logic [7:0] bank;
      logic [31:0] val;
      logic [31:0] accu;
      logic [31:0] x;
      logic persist;
      logic coord_we;
      logic coord_nv_we;
      logic ap_we;
      logic gp_we;
      logic [31:0] wr_data;
      logic reply_valid;
      logic [7:0] reply_status;
      logic [31:0] reply_value;
   } atx_alu_t;

   atx_alu_t st, next_st;
   logic div_start, div_done, exec_ok;
   logic [31:0] div_quo, div_rem;

   assign exec_ok = st.state == atx_pkg::ATX_EXEC && st.adr_ok && st.chk_ok;
   // a started frame keeps the port until its ninth byte
   assign sa_ready = st.state == atx_pkg::ATX_IDLE && st.cnt == 4'h0;
   assign rx_ready = st.state == atx_pkg::ATX_IDLE && !(sa_valid && st.cnt == 4'h0);

   always_comb begin
      next_st = st;
      div_start = 1'b0;
      next_st.coord_we = 1'b0;
      next_st.coord_nv_we = 1'b0;
      next_st.ap_we = 1'b0;
      next_st.gp_we = 1'b0;
      next_st.reply_valid = 1'b0;
      case (st.state)
         atx_pkg::ATX_IDLE: begin
            if (sa_valid && sa_ready) begin
               next_st.op = sa_op;
               next_st.typ = sa_type;
               next_st.bank = sa_bank;
               next_st.val = sa_value;
               next_st.direct = 1'b0;
               next_st.adr_ok = 1'b1;
               next_st.chk_ok = 1'b1;
               next_st.state = atx_pkg::ATX_EXEC;
            end else if (rx_valid && rx_ready) begin
               next_st.sum = st.sum + rx_data; // [RULE_13]
               next_st.cnt = st.cnt + 4'h1;
               case (st.cnt) // [RULE_11]
                  atx_pkg::FB_ADDR: begin
                     next_st.sum = rx_data;
                     next_st.adr_ok = rx_data == MODULE_ADDR;
                  end
                  atx_pkg::FB_OP: next_st.op = rx_data;
                  atx_pkg::FB_TYPE: next_st.typ = rx_data;
                  atx_pkg::FB_BANK: next_st.bank = rx_data;
                  atx_pkg::FB_CHK: begin
                     next_st.chk_ok = st.sum == rx_data; // [RULE_13]
                     next_st.cnt = 4'h0;
                     next_st.direct = 1'b1;
                     next_st.state = atx_pkg::ATX_EXEC;
                  end
                  default: next_st.val = {st.val[23:0], rx_data};
               endcase
            end
         end
         atx_pkg::ATX_EXEC: begin
            next_st.state = atx_pkg::ATX_IDLE;
            next_st.reply_valid = st.direct && st.adr_ok;
            next_st.reply_status = atx_pkg::ST_OK; // [RULE_04]
            next_st.reply_value = 32'h0000_0000;
            next_st.wr_data = st.accu;
            if (!st.chk_ok) begin
               next_st.reply_status = atx_pkg::ST_BAD_CHK; // [RULE_13]
            end else if (st.adr_ok) begin
               case (st.op)
                  atx_pkg::OP_ACCU_TO_COORD: begin
                     next_st.coord_we = 1'b1; // [RULE_01]
                     // entry zero stays volatile whatever the switch
                     next_st.coord_nv_we = st.persist &&
                        st.typ != atx_pkg::COORD_RAM_ONLY; // [RULE_02] [RULE_03]
                  end
                  atx_pkg::OP_ACCU_TO_AXIS: next_st.ap_we = 1'b1; // [RULE_09]
                  atx_pkg::OP_ACCU_TO_GLOBAL: begin
                     next_st.gp_we = 1'b1; // [RULE_10]
                     if (st.bank == atx_pkg::GP_PERSIST_BANK &&
                         st.typ == atx_pkg::GP_COORD_PERSIST) begin
                        next_st.persist = st.accu != atx_pkg::ACCU_RST; // [RULE_03]
                     end
                  end
                  atx_pkg::OP_WITH_IMMEDIATE_A_X: begin
                     case (st.typ) // [RULE_05]
                        atx_pkg::TY_ADD: next_st.accu = st.accu + st.x; // [RULE_06] [RULE_14]
                        atx_pkg::TY_SUB: next_st.accu = st.accu - st.x; // [RULE_06]
                        atx_pkg::TY_MUL: next_st.accu = st.accu * st.x; // [RULE_06] [RULE_14]
                        atx_pkg::TY_DIV, atx_pkg::TY_MOD: begin
                           // divide by zero leaves the accumulator alone
                           if (st.x != atx_pkg::ACCU_RST) begin
                              div_start = 1'b1; // [RULE_06]
                              next_st.reply_valid = 1'b0;
                              next_st.state = atx_pkg::ATX_DIV;
                           end
                        end
                        atx_pkg::TY_AND: next_st.accu = st.accu & st.x; // [RULE_07]
                        atx_pkg::TY_OR: next_st.accu = st.accu | st.x; // [RULE_07]
                        atx_pkg::TY_XOR: next_st.accu = st.accu ^ st.x; // [RULE_07]
                        atx_pkg::TY_NOT: next_st.x = ~st.x; // [RULE_07]
                        atx_pkg::TY_LOAD: next_st.x = st.accu; // [RULE_08]
                        atx_pkg::TY_SWAP: begin
                           next_st.accu = st.x; // [RULE_08]
                           next_st.x = st.accu;
                        end
                        default: next_st.reply_status = atx_pkg::ST_BAD_TYPE;
                     endcase
                  end
                  default: begin
                     if (st.op == READ_AXIS_CODE) begin
                        if (st.direct) begin
                           next_st.reply_value = ap_rd_data; // [RULE_12]
                        end else begin
                           next_st.accu = ap_rd_data; // [RULE_12]
                        end
                     end else begin
                        next_st.reply_status = atx_pkg::ST_BAD_CMD;
                     end
                  end
               endcase
            end
         end
         atx_pkg::ATX_DIV: begin
            if (div_done) begin
               next_st.accu = st.typ == atx_pkg::TY_MOD ? div_rem : div_quo; // [RULE_06]
               next_st.reply_valid = st.direct;
               next_st.reply_status = atx_pkg::ST_OK; // [RULE_04]
               next_st.state = atx_pkg::ATX_IDLE;
            end
         end
         default: next_st.state = atx_pkg::ATX_IDLE;
      endcase
   end
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         st <= '0; // persistence off: volatile coordinates [RULE_03]
      end else begin
         st <= next_st;
      end
   end
   atx_div u_div (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .start(div_start),
      .dividend(st.accu),
      .divisor(st.x),
      .done(div_done),
      .quotient(div_quo),
      .remainder(div_rem)
   );
   assign reply_valid = st.reply_valid;
   assign reply_status = st.reply_status;
   assign reply_value = st.reply_value;
   assign sel_type = st.typ;
   assign sel_bank = st.bank;
   assign wr_data = st.wr_data;
   assign coord_we = st.coord_we;
   assign coord_nv_we = st.coord_nv_we;
   assign coord_persist = st.persist;
   assign ap_we = st.ap_we;
   assign gp_we = st.gp_we;
   assign accu = st.accu;
   assign x_reg = st.x;

   property p_coord_data;
      @(posedge core_clk) disable iff (!arst_n)
      coord_we |-> wr_data == accu && sel_type == $past(st.typ);
   endproperty
   a_coord_data: assert property (p_coord_data) // [RULE_01]
      else $error("coordinate write does not carry the accumulator");
   property p_coord_zero_volatile;
      @(posedge core_clk) disable iff (!arst_n)
      coord_nv_we |-> sel_type != atx_pkg::COORD_RAM_ONLY && coord_we;
   endproperty
   a_coord_zero_volatile: assert property (p_coord_zero_volatile) // [RULE_02]
      else $error("coordinate zero sent to nonvolatile storage");
   property p_persist_gate;
      @(posedge core_clk) disable iff (!arst_n)
      (coord_we && !coord_nv_we && sel_type != atx_pkg::COORD_RAM_ONLY) |-> !coord_persist;
   endproperty
   a_persist_gate: assert property (p_persist_gate) // [RULE_03]
      else $error("persistent coordinate not sent to nonvolatile storage");
   property p_add_wraps;
      @(posedge core_clk) disable iff (!arst_n)
      (exec_ok && st.op == atx_pkg::OP_WITH_IMMEDIATE_A_X && st.typ == atx_pkg::TY_ADD)
         |=> accu == $past(st.accu) + $past(st.x) && x_reg == $past(st.x);
   endproperty
   a_add_wraps: assert property (p_add_wraps) // [RULE_14]
      else $error("add result wrong");
   property p_swap;
      @(posedge core_clk) disable iff (!arst_n)
      (exec_ok && st.op == atx_pkg::OP_WITH_IMMEDIATE_A_X && st.typ == atx_pkg::TY_SWAP)
         |=> accu == $past(st.x) && x_reg == $past(st.accu);
   endproperty
   a_swap: assert property (p_swap) // [RULE_08]
      else $error("swap did not exchange accumulator and x");
   property p_not_x;
      @(posedge core_clk) disable iff (!arst_n)
      (exec_ok && st.op == atx_pkg::OP_WITH_IMMEDIATE_A_X && st.typ == atx_pkg::TY_NOT)
         |=> x_reg == ~$past(st.x) && accu == $past(st.accu);
   endproperty
   a_not_x: assert property (p_not_x) // [RULE_07]
      else $error("invert of x wrong");
   property p_param_writes;
      @(posedge core_clk) disable iff (!arst_n)
      (ap_we || gp_we) |-> wr_data == accu && !(ap_we && gp_we);
   endproperty
   a_param_writes: assert property (p_param_writes) // [RULE_09] [RULE_10]
      else $error("parameter write does not carry the accumulator");
   property p_direct_read_keeps_accu;
      @(posedge core_clk) disable iff (!arst_n)
      (exec_ok && st.direct && st.op == READ_AXIS_CODE)
         |=> accu == $past(st.accu) && reply_valid && reply_value == $past(ap_rd_data);
   endproperty
   a_direct_read_keeps_accu: assert property (p_direct_read_keeps_accu) // [RULE_12]
      else $error("direct read touched the accumulator");
   property p_bad_checksum;
      @(posedge core_clk) disable iff (!arst_n)
      (rx_valid && rx_ready && st.adr_ok && st.cnt == atx_pkg::FB_CHK && st.sum != rx_data)
         |-> ##2 reply_valid && reply_status == atx_pkg::ST_BAD_CHK && !coord_we && !ap_we;
   endproperty
   a_bad_checksum: assert property (p_bad_checksum) // [RULE_13]
      else $error("bad checksum not refused");
   property p_ok_reply;
      @(posedge core_clk) disable iff (!arst_n)
      (exec_ok && st.direct && st.op == atx_pkg::OP_ACCU_TO_AXIS)
         |=> reply_valid && reply_status == atx_pkg::ST_OK;
   endproperty
   a_ok_reply: assert property (p_ok_reply) // [RULE_04]
      else $error("missing ok reply");
endmodule : atx_accu_alu

// ---- atx_host.sv ----
`timescale 1ns/100ps
module atx_host (
   // clock
   input wire logic core_clk,
   // frame byte handshake
   input wire logic rx_ready,
   output logic rx_valid,
   output logic [7:0] rx_data
);
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
   end

   // bad flips the checksum lsb so the receiver must refuse the frame
   task automatic send_frame(input logic [7:0] adr, op, ty, bk, input logic [31:0] val,
                             input logic bad);
      logic [7:0] b [9];
      b = '{adr, op, ty, bk, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
      for (int i = 0; i < 8; i++) b[8] = b[8] + b[i];
      b[8] = b[8] ^ {7'h00, bad};
      // entered just after an edge, so every byte moves at the same offset
      rx_valid = 1'b1;
      for (int i = 0; i < 9; i++) begin
         rx_data = b[i];
         @(posedge core_clk);
         while (!rx_ready) @(posedge core_clk);
         #1;
      end
      rx_valid = 1'b0;
      // released line: never leave the last byte standing
      rx_data = ~b[8];
   endtask : send_frame
endmodule : atx_host

// ---- testbench.sv ----
`timescale 1ns/100ps
module testbench;
   localparam logic [7:0] RD_CODE = 8'h06;
   localparam logic [31:0] ACC_A = 32'h1234_5678;
   typedef struct {logic [7:0] ty; logic [31:0] a, x, ea, ex;} atx_with_immediate_a_row_t;
   typedef struct {logic [7:0] op, ty, bk; logic [31:0] val; logic bad;
                   logic [7:0] st; logic [3:0] m;} atx_dir_row_t;

   logic core_clk = 1'b0;
   logic arst_n, rx_valid, rx_ready, sa_valid, sa_ready, reply_valid;
   logic coord_we, coord_nv_we, coord_persist, ap_we, gp_we;
   logic [7:0] rx_data, sa_op, sa_type, sa_bank, reply_status, sel_type, sel_bank;
   logic [31:0] sa_value, reply_value, wr_data, ap_rd_data, accu, x_reg;
   logic [31:0] strobes;
   int n_errors = 0;
   int comparisons = 0;

   // ty, accu, x, expected accu, expected x
   atx_with_immediate_a_row_t with_immediate_a_rows [13] = '{
      '{8'h00, 32'h7fff_ffff, 32'h0000_0001, 32'h8000_0000, 32'h0000_0001},
      '{8'h01, 32'h0000_0005, 32'h0000_0007, 32'hffff_fffe, 32'h0000_0007},
      '{8'h02, 32'h0001_0000, 32'h0001_0001, 32'h0001_0000, 32'h0001_0001},
      '{8'h03, 32'hffff_fff9, 32'h0000_0002, 32'hffff_fffd, 32'h0000_0002},
      '{8'h03, 32'h8000_0000, 32'hffff_ffff, 32'h8000_0000, 32'hffff_ffff},
      '{8'h03, 32'h0000_0005, 32'h0000_0000, 32'h0000_0005, 32'h0000_0000},
      '{8'h04, 32'hffff_fff9, 32'h0000_0002, 32'hffff_ffff, 32'h0000_0002},
      '{8'h05, 32'hf0f0_f0f0, 32'hff00_ff00, 32'hf000_f000, 32'hff00_ff00},
      '{8'h06, 32'hf0f0_f0f0, 32'hff00_ff00, 32'hfff0_fff0, 32'hff00_ff00},
      '{8'h07, 32'hf0f0_f0f0, 32'hff00_ff00, 32'h0ff0_0ff0, 32'hff00_ff00},
      '{8'h08, 32'hf0f0_f0f0, 32'hff00_ff00, 32'hf0f0_f0f0, 32'h00ff_00ff},
      '{8'h09, 32'hf0f0_f0f0, 32'hff00_ff00, 32'hf0f0_f0f0, 32'hf0f0_f0f0},
      '{8'h0a, 32'hf0f0_f0f0, 32'hff00_ff00, 32'hff00_ff00, 32'hf0f0_f0f0}};

   // strobe mask m is {coord, coord nonvolatile, axis, global}
   atx_dir_row_t dir_rows [10] = '{
      '{8'h27, 8'h01, 8'h00, 32'h0000_00ff, 1'b0, 8'h64, 4'h8},
      '{8'h27, 8'h00, 8'h00, 32'h0000_0000, 1'b0, 8'h64, 4'h8},
      '{8'h22, 8'h04, 8'h00, 32'h0000_0000, 1'b0, 8'h64, 4'h2},
      '{8'h23, 8'h2a, 8'h02, 32'h0000_0000, 1'b0, 8'h64, 4'h1},
      '{8'h23, 8'h54, 8'h00, 32'h0000_0000, 1'b0, 8'h64, 4'h1},
      '{8'h27, 8'h03, 8'h00, 32'h0000_0000, 1'b0, 8'h64, 4'hc},
      '{8'h27, 8'h00, 8'h00, 32'h0000_0000, 1'b0, 8'h64, 4'h8},
      '{8'h27, 8'h01, 8'h00, 32'h0000_0000, 1'b1, 8'h01, 4'h0},
      '{8'h30, 8'h00, 8'h00, 32'h0000_0000, 1'b0, 8'h02, 4'h0},
      '{8'h21, 8'h0b, 8'h00, 32'h0000_0000, 1'b0, 8'h03, 4'h0}};

   always #10 core_clk = ~core_clk;

   assign strobes = {28'h0000000, coord_we, coord_nv_we, ap_we, gp_we};

   atx_accu_alu #(.MODULE_ADDR(8'h01), .READ_AXIS_CODE(RD_CODE)) i_dut (
      .core_clk(core_clk), .arst_n(arst_n), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_ready(rx_ready), .sa_valid(sa_valid), .sa_op(sa_op), .sa_type(sa_type),
      .sa_bank(sa_bank), .sa_value(sa_value), .sa_ready(sa_ready),
      .reply_valid(reply_valid), .reply_status(reply_status), .reply_value(reply_value),
      .sel_type(sel_type), .sel_bank(sel_bank), .wr_data(wr_data), .coord_we(coord_we),
      .coord_nv_we(coord_nv_we), .coord_persist(coord_persist), .ap_we(ap_we),
      .gp_we(gp_we), .ap_rd_data(ap_rd_data), .accu(accu), .x_reg(x_reg));

   atx_host i_host (.core_clk(core_clk), .rx_ready(rx_ready), .rx_valid(rx_valid),
      .rx_data(rx_data));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic finish_test();
      $display("comparisons %0d n_errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : finish_test

   // entered just after an edge; returns in the cycle the effects show
   task automatic sa_cmd(input logic [7:0] op, input logic [7:0] ty);
      int n;
      n = 0;
      sa_op = op;
      sa_type = ty;
      sa_valid = 1'b1;
      @(posedge core_clk);
      while (!sa_ready) @(posedge core_clk);
      #1;
      sa_valid = 1'b0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (sa_ready !== 1'b1 && n < 60);
      if (n >= 60) chk(n, 0);
   endtask : sa_cmd

   task automatic load_accu(input logic [31:0] v);
      ap_rd_data = v;
      sa_cmd(RD_CODE, 8'h01);
   endtask : load_accu

   task automatic dframe(input atx_dir_row_t r);
      int n;
      n = 0;
      i_host.send_frame(8'h01, r.op, r.ty, r.bk, r.val, r.bad);
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (reply_valid !== 1'b1 && n < 60);
      if (n >= 60) chk(n, 0);
   endtask : dframe

   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      $display("Error at %0t: timeout %h %h", $time, sa_ready, rx_ready);
      finish_test();
   end

   initial begin
      arst_n = 1'b0;
      sa_valid = 1'b0;
      sa_op = 8'h00;
      sa_type = 8'h00;
      sa_bank = 8'h00;
      sa_value = 32'h0000_0000;
      ap_rd_data = 32'h0000_0000;
      repeat (10) @(posedge core_clk);
      #1;
      arst_n = 1'b1;
      chk(32'(coord_persist), 32'h0);
      chk(accu, 32'h0);
      chk(x_reg, 32'h0);
      foreach (with_immediate_a_rows[i]) begin
         load_accu(with_immediate_a_rows[i].x);
         sa_cmd(atx_pkg::OP_WITH_IMMEDIATE_A_X, atx_pkg::TY_LOAD);
         load_accu(with_immediate_a_rows[i].a);
         sa_cmd(atx_pkg::OP_WITH_IMMEDIATE_A_X, with_immediate_a_rows[i].ty);
         chk(accu, with_immediate_a_rows[i].ea);
         chk(x_reg, with_immediate_a_rows[i].ex);
      end
      load_accu(ACC_A);
      chk(accu, ACC_A);
      foreach (dir_rows[i]) begin
         dframe(dir_rows[i]);
         chk(32'(reply_status), 32'(dir_rows[i].st));
         chk(strobes, 32'(dir_rows[i].m));
         if (dir_rows[i].m != 4'h0) begin
            chk(wr_data, ACC_A);
            chk(32'(sel_type), 32'(dir_rows[i].ty));
            chk(32'(sel_bank), 32'(dir_rows[i].bk));
         end
         chk(accu, ACC_A);
      end
      chk(32'(coord_persist), 32'h1);
      // direct read answers in the reply only
      ap_rd_data = 32'hcafe_0001;
      dframe('{RD_CODE, 8'h01, 8'h00, 32'h0, 1'b0, 8'h64, 4'h0});
      chk(reply_value, 32'hcafe_0001);
      chk(accu, ACC_A);
      // reset in mid-run drops persistence back to volatile only
      arst_n = 1'b0;
      #1;
      chk(32'(coord_persist), 32'h0);
      chk(accu, 32'h0);
      repeat (10) @(posedge core_clk);
      #1;
      arst_n = 1'b1;
      // persistence is off again, so coordinate 3 stays volatile
      dframe(dir_rows[5]);
      chk(strobes, 32'h8);
      chk(wr_data, 32'h0);
      finish_test();
   end
endmodule : testbench
